// [hw/udw_pkg.sv]
package udw_pkg;
    // interface timing in ns, store and power-up waits in ms
    localparam int CLK_PERIOD_NS = 40;
    localparam int SEL_TO_STROBE_NS = 50;
    localparam int STROBE_HIGH_TO_DIR_NS = 100;
    localparam int DIR_TO_STROBE_NS = 1000;
    localparam int STROBE_LOW_NS = 960;
    localparam int STROBE_HIGH_NS = 960;
    localparam int STROBE_TO_DESELECT_NS = 1000;
    localparam int NOSTORE_DESELECT_NS = 100;
    localparam int STORE_DESELECT_MS = 10;
    localparam int POWERUP_SETTLE_MS = 1;
    localparam int NS_PER_MS = 1000000;

    // least times round up to whole cycles
    function automatic int udw_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : udw_cyc

    localparam int SEL_TO_STROBE_CYC = udw_cyc(SEL_TO_STROBE_NS);
    localparam int DIR_SETUP_CYC = udw_cyc(DIR_TO_STROBE_NS);
    localparam int DIR_HOLD_CYC = udw_cyc(STROBE_HIGH_TO_DIR_NS);
    localparam int STROBE_LOW_CYC = udw_cyc(STROBE_LOW_NS);
    localparam int STROBE_HIGH_CYC = udw_cyc(STROBE_HIGH_NS);
    localparam int STROBE_TO_DESELECT_CYC = udw_cyc(STROBE_TO_DESELECT_NS);
    localparam int NOSTORE_DESELECT_CYC = udw_cyc(NOSTORE_DESELECT_NS);
    localparam int STORE_DESELECT_CYC_DEF = (STORE_DESELECT_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int POWERUP_SETTLE_CYC_DEF = (POWERUP_SETTLE_MS * NS_PER_MS) / CLK_PERIOD_NS;

    localparam int POS_WIDTH = 7;
    localparam int STEP_WIDTH = 7;
    localparam int CNT_WIDTH = 20;
    localparam logic [POS_WIDTH-1:0] POS_MAX = 7'h63;

    typedef enum logic [3:0] {
        UDW_POWERUP, UDW_IDLE, UDW_SEL_SETUP, UDW_DIR_SETUP, UDW_STROBE_LOW,
        UDW_STROBE_HIGH, UDW_PRE_DESEL, UDW_DESEL, UDW_GUARD
    } udw_state_e;
endpackage : udw_pkg

// [hw/udw_timer.sv]
`timescale 1ns/1ps
// loadable down counter; done is high while the count is zero
module udw_timer #(
    parameter int WIDTH = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic done
);
    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign done = (count_reg == '0);
endmodule : udw_timer

// [hw/udw_host.sv]
`timescale 1ns/1ps
// Summary of operation
// [R1] device acts on strobe and direction only while select is low
// [R2] each strobe falling edge moves the device position one step
// [R3] device position is a 7-bit counter choosing one of 100 taps
// [R4] one tap switch at a time joins the array to the wiper
// [R5] position saturates at both ends and never wraps
// [R6] raising select with strobe high stores position to nonvolatile memory
// [R7] after a store the device sits in standby until selected again
// [R8] raise select with strobe low to deselect without storing
// [R9] at power restoration the device recalls the stored position
// [R10] direction may change within one selection between steps; the host sets dir_up once per command and holds it while selected
// [R11] after a store keep select high at least 10 ms
// [R12] after a no-store deselect keep select high at least 100 ns
// [R13] wait 1 us after strobe goes inactive before raising select
// [R14] select and strobe are driven high from power-up
// [R15] do not use the interface until 1 ms after power settles
// [R16] device wiper is stable within 5 us of power-up
// [R17] direction high increments, low decrements
// [R18] position stays within 0 to 99
module udw_host
    import udw_pkg::*;
#(
    parameter int STORE_DESELECT_CYC = udw_pkg::STORE_DESELECT_CYC_DEF,
    parameter int POWERUP_SETTLE_CYC = udw_pkg::POWERUP_SETTLE_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_up,
    input wire logic [udw_pkg::STEP_WIDTH-1:0] cmd_steps,
    input wire logic cmd_store,
    input wire logic [udw_pkg::POS_WIDTH-1:0] recalled_pos,
    output logic [udw_pkg::POS_WIDTH-1:0] pos_estimate,
    output logic busy,
    output logic select_n,
    output logic strobe_n,
    output logic dir_up
);
    import udw_pkg::*;

    logic rst_meta_reg;
    logic rst_n;
    udw_state_e state_reg;
    logic [STEP_WIDTH-1:0] steps_left_reg;
    logic store_reg;
    logic [POS_WIDTH-1:0] pos_reg;
    logic recall_reg;
    logic tmr_load;
    logic [CNT_WIDTH-1:0] tmr_value;
    logic tmr_done;
    logic [CNT_WIDTH-1:0] gap_cnt_reg;
    logic had_steps_reg;
    logic [POS_WIDTH-1:0] recall_meta_reg;
    logic [POS_WIDTH-1:0] recall_sync_reg;

    // recalled position comes from the device pins; two stages before use, running through reset
    always_ff @(posedge clk_sys) begin
        recall_meta_reg <= recalled_pos;
        recall_sync_reg <= recall_meta_reg;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    function automatic logic [CNT_WIDTH-1:0] udw_len(input int cyc);
        return CNT_WIDTH'(cyc);
    endfunction : udw_len

    udw_timer #(.WIDTH(CNT_WIDTH)) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_value(tmr_value),
        .done(tmr_done)
    );

    // timer load follows each state entry except the entry to UDW_IDLE
    always_comb begin
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state_reg)
            UDW_IDLE: begin
                if (cmd_valid) begin
                    tmr_load = 1'b1;
                    tmr_value = udw_len(SEL_TO_STROBE_CYC);
                end
            end
            UDW_SEL_SETUP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = udw_len(DIR_SETUP_CYC);
                end
            end
            UDW_DIR_SETUP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = udw_len(STROBE_LOW_CYC);
                end
            end
            UDW_STROBE_LOW: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = udw_len(STROBE_HIGH_CYC);
                end
            end
            UDW_STROBE_HIGH: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = (steps_left_reg != '0) ? udw_len(STROBE_LOW_CYC) : udw_len(STROBE_TO_DESELECT_CYC);
                end
            end
            UDW_PRE_DESEL: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_value = store_reg ? udw_len(STORE_DESELECT_CYC) : udw_len(NOSTORE_DESELECT_CYC); // see [R11] see [R12]
                end
            end
            default: begin
                tmr_load = 1'b0;
                tmr_value = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= UDW_POWERUP;
        end else begin
            case (state_reg)
                UDW_POWERUP: if (gap_cnt_reg >= udw_len(POWERUP_SETTLE_CYC)) state_reg <= UDW_IDLE; // see [R15]
                UDW_IDLE: if (cmd_valid) state_reg <= UDW_SEL_SETUP;
                UDW_SEL_SETUP: if (tmr_done) state_reg <= UDW_DIR_SETUP;
                UDW_DIR_SETUP: if (tmr_done) state_reg <= UDW_STROBE_LOW;
                UDW_STROBE_LOW: if (tmr_done) state_reg <= UDW_STROBE_HIGH;
                UDW_STROBE_HIGH: begin
                    if (tmr_done) state_reg <= (steps_left_reg != '0) ? UDW_STROBE_LOW : UDW_PRE_DESEL;
                end
                UDW_PRE_DESEL: if (tmr_done) state_reg <= UDW_DESEL;
                UDW_DESEL: if (tmr_done) state_reg <= UDW_IDLE;
                default: state_reg <= UDW_IDLE;
            endcase
        end
    end

    // power-up settle counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt_reg <= '0;
        end else if (state_reg == UDW_POWERUP) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            steps_left_reg <= '0;
            store_reg <= 1'b0;
            had_steps_reg <= 1'b0;
            dir_up <= 1'b1;
        end else if (state_reg == UDW_IDLE && cmd_valid) begin
            // zero steps with no store leaves select and strobe idle; dir_up still takes cmd_up
            steps_left_reg <= cmd_steps;
            store_reg <= cmd_store;
            had_steps_reg <= (cmd_steps != '0);
            dir_up <= cmd_up; // see [R10] see [R17]
        end else if (state_reg == UDW_STROBE_LOW && tmr_done && steps_left_reg != '0) begin
            steps_left_reg <= steps_left_reg - 1'b1;
        end
    end

    // pins: select and strobe high from reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            select_n <= 1'b1; // see [R14]
            strobe_n <= 1'b1; // see [R14]
        end else begin
            select_n <= !((state_reg inside {UDW_SEL_SETUP, UDW_DIR_SETUP, UDW_STROBE_LOW,
                                              UDW_STROBE_HIGH, UDW_PRE_DESEL}) && (store_reg || had_steps_reg)); // see [R1]
            // no store: the last strobe stays low through deselect, so no extra falling edge is made
            strobe_n <= !((state_reg == UDW_STROBE_LOW && steps_left_reg != '0)
                          || (!store_reg && had_steps_reg && steps_left_reg == '0
                              && state_reg inside {UDW_STROBE_HIGH, UDW_PRE_DESEL, UDW_DESEL})); // see [R2] see [R8] see [R6]
        end
    end

    // tracks device position with saturation at 0 and 99
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            recall_reg <= 1'b1;
            pos_reg <= '0;
        end else if (recall_reg) begin
            recall_reg <= 1'b0;
            pos_reg <= (recall_sync_reg > POS_MAX) ? POS_MAX : recall_sync_reg; // see [R9]
        end else if (state_reg == UDW_STROBE_LOW && tmr_done && steps_left_reg != '0) begin
            if (dir_up && pos_reg != POS_MAX) pos_reg <= pos_reg + 1'b1; // see [R5] see [R18]
            else if (!dir_up && pos_reg != '0) pos_reg <= pos_reg - 1'b1; // see [R5] see [R18]
        end
    end

    assign pos_estimate = pos_reg;
    assign cmd_ready = (state_reg == UDW_IDLE);
    assign busy = (state_reg != UDW_IDLE);

    a_deselect_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(select_n) |-> select_n [*3]) // see [R12]
        else $error("select reasserted too soon");
    a_pos_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pos_reg <= POS_MAX) // see [R18]
        else $error("position out of range");
    a_strobe_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(strobe_n) |-> !select_n) // see [R1]
        else $error("strobe fell while deselected");
    a_dir_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !select_n && $changed(dir_up) |-> 0) // see [R10]
        else $error("direction moved mid selection");
    a_store_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(select_n) && store_reg |-> strobe_n) // see [R6]
        else $error("store deselect without strobe high");
    a_nostore_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(select_n) && !store_reg |-> !strobe_n) // see [R8]
        else $error("no-store deselect with strobe high");
    a_strobe_settle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(strobe_n) && !select_n |-> (!select_n) [*8]) // see [R13]
        else $error("deselect too soon after strobe");
    a_sat_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(pos_reg) == POS_MAX && !recall_reg && $past(dir_up) |-> pos_reg == POS_MAX) // see [R5]
        else $error("position wrapped at top");
endmodule : udw_host

// [tb/udw_dev_model.sv]
`timescale 1ns/1ps
module udw_dev_model #(
    parameter logic [6:0] NV_INIT = 7'h2A,
    parameter real STORE_GAP_NS = 2000.0
) (
    input wire logic power_up,
    input wire logic select_n,
    input wire logic strobe_n,
    input wire logic dir_up,
    output logic [6:0] pos,
    output logic [6:0] nv,
    output int viol
);
    real t_rise;
    real t_desel;
    logic stored;
    logic standby;

    initial begin
        nv = NV_INIT;
        pos = NV_INIT;
        viol = 0;
        t_rise = 0.0;
        t_desel = 0.0;
        stored = 1'b0;
        standby = 1'b1;
    end
    always @(posedge power_up) pos = nv;
    always @(posedge strobe_n) t_rise = $realtime;
    // pos picks exactly one of the hundred taps
    always @(negedge strobe_n) begin
        if (power_up && select_n === 1'b0) begin
            if (dir_up === 1'b1 && pos < 7'h63) pos = pos + 7'h01;
            else if (dir_up === 1'b0 && pos > 7'h00) pos = pos - 7'h01;
        end
    end
    always @(posedge select_n) begin
        if (power_up) begin
            stored = (strobe_n === 1'b1);
            if (stored) nv = pos;
            if (stored && $realtime - t_rise < 1000.0) viol++;
            standby = stored;
            t_desel = $realtime;
        end
    end
    always @(negedge select_n) begin
        if (power_up && $realtime - t_desel < (stored ? STORE_GAP_NS : 100.0)) viol++;
        standby = 1'b0;
    end
endmodule : udw_dev_model

// [tb/udw_host_bench.sv]
`timescale 1ns/1ps
module udw_host_bench;
    import udw_pkg::*;
    localparam int STORE_CYC = 50;
    logic clk_sys;
    logic reset_n;
    logic cmd_valid;
    logic cmd_ready;
    logic cmd_up;
    logic [STEP_WIDTH-1:0] cmd_steps;
    logic cmd_store;
    logic [POS_WIDTH-1:0] pos_estimate;
    logic busy;
    logic select_n;
    logic strobe_n;
    logic dir_up;
    logic power_up;
    logic [POS_WIDTH-1:0] dev_pos;
    logic [POS_WIDTH-1:0] dev_nv;
    int dev_viol;
    int errors;
    int compares;
    int exp_pos;
    int exp_nv;
    logic [15:0] lfsr;

    udw_host #(.STORE_DESELECT_CYC(STORE_CYC), .POWERUP_SETTLE_CYC(20)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_up(cmd_up), .cmd_steps(cmd_steps), .cmd_store(cmd_store), .recalled_pos(dev_pos),
        .pos_estimate(pos_estimate), .busy(busy), .select_n(select_n), .strobe_n(strobe_n),
        .dir_up(dir_up));
    udw_dev_model #(.NV_INIT(7'h2A), .STORE_GAP_NS(STORE_CYC * CLK_PERIOD_NS * 1.0)) dev (
        .power_up(power_up), .select_n(select_n), .strobe_n(strobe_n), .dir_up(dir_up),
        .pos(dev_pos), .nv(dev_nv), .viol(dev_viol));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        if (errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // one command: wait ready, pulse valid for one edge, wait for idle, compare
    task automatic move(input logic up, input int n, input logic st);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 10000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 10000) errors++;
        cmd_valid = 1'b1;
        cmd_up = up;
        cmd_steps = n[6:0];
        cmd_store = st;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 10000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 10000) errors++;
        for (k = 0; k < n; k++) begin
            if (up && exp_pos < int'(POS_MAX)) exp_pos++;
            else if (!up && exp_pos > 0) exp_pos--;
        end
        if (st) exp_nv = exp_pos;
        check("pos_estimate", exp_pos[6:0], pos_estimate);
        check("device_pos", exp_pos[6:0], dev_pos);
        check("device_nv", exp_nv[6:0], dev_nv);
    endtask : move

    task automatic power_cycle();
        reset_n = 1'b0;
        power_up = 1'b0;
        repeat (10) @(negedge clk_sys);
        check("select_n_reset", 7'h01, {6'h00, select_n});
        check("strobe_n_reset", 7'h01, {6'h00, strobe_n});
        reset_n = 1'b1;
        power_up = 1'b1;
        exp_pos = exp_nv;
        move(1'b0, 0, 1'b0);
    endtask : power_cycle

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        conclude();
    end
    initial begin
        errors = 0;
        compares = 0;
        reset_n = 1'b0;
        power_up = 1'b0;
        cmd_valid = 1'b0;
        cmd_up = 1'b0;
        cmd_steps = 7'h00;
        cmd_store = 1'b0;
        lfsr = 16'h83C2;
        exp_nv = int'(7'h2A);
        power_cycle();
        move(1'b1, 5, 1'b0);
        move(1'b0, 100, 1'b0);
        move(1'b1, 127, 1'b0);
        move(1'b0, 3, 1'b1);
        move(1'b1, 0, 1'b1);
        move(1'b0, 9, 1'b0);
        power_cycle();
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            move(lfsr[0], int'(lfsr[7:1]), lfsr[8]);
        end
        check("host_timing", 7'h00, dev_viol[6:0]);
        conclude();
    end
endmodule : udw_host_bench
